// file: hdl/uag_pkg.sv
// Shared constants and carrier types for the upper address pin port.
// Assumes a 40 MHz system clock and a byte-wide register file on AHB-Lite.

package uag_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int UAG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [15:0] UAG_IDX_DIR   = 16'hffc1;
  localparam logic [15:0] UAG_IDX_LATCH = 16'hffc3;
  localparam logic [15:0] UAG_IDX_PULL  = 16'hffd8;
  localparam logic [17:0] UAG_ADDR_DIR   = {UAG_IDX_DIR, 2'h0};
  localparam logic [17:0] UAG_ADDR_LATCH = {UAG_IDX_LATCH, 2'h0};
  localparam logic [17:0] UAG_ADDR_PULL  = {UAG_IDX_PULL, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and fixed read values
  localparam logic [7:0] UAG_DIR_RST_EXP = 8'hff;
  localparam logic [7:0] UAG_DIR_RST_GP  = 8'h00;
  localparam logic [7:0] UAG_LATCH_RST   = 8'h00;
  localparam logic [7:0] UAG_PULL_RST    = 8'h00;
  localparam logic [7:0] UAG_DIR_READ    = 8'hff;
  localparam logic [7:0] UAG_ZERO8       = 8'h00;
  localparam logic [23:0] UAG_PAD24      = 24'h00_0000;

  // Operating mode codes
  localparam logic [2:0] UAG_MODE_NONE = 3'h0;
  localparam logic [2:0] UAG_MODE_1    = 3'h1;
  localparam logic [2:0] UAG_MODE_4    = 3'h4;
  localparam logic [2:0] UAG_MODE_5    = 3'h5;
  localparam logic [2:0] UAG_MODE_6    = 3'h6;
  localparam logic [2:0] UAG_MODE_7    = 3'h7;

  // Pins carrying row/column bits when DRAM sits in area three
  localparam int UAG_DRAM_BITS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef enum logic [1:0]
  {
    UAG_SEL_NONE  = 2'h0,
    UAG_SEL_DIR   = 2'h1,
    UAG_SEL_LATCH = 2'h2,
    UAG_SEL_PULL  = 2'h3
  } uag_sel_t;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    uag_sel_t   sel;
    logic [7:0] wdata;
  } uag_req_t;

  typedef enum logic [1:0]
  {
    UAG_SL_IDLE   = 2'h0,
    UAG_SL_WRITE  = 2'h1,
    UAG_SL_RDWAIT = 2'h2,
    UAG_SL_RDDONE = 2'h3
  } uag_slv_state_t;

endpackage

// file: hdl/uag_sync.sv
// Two-stage level synchroniser for pin inputs.
// Assumes the inputs are slow levels; the first stage feeds only the second.
`timescale 1ns/10ps

module uag_sync
  import uag_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } uag_sync_state_t;

  uag_sync_state_t s;
  uag_sync_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Stage chain
  always_comb
  begin
    next_s.meta   = async_in;
    next_s.stable = s.meta;
  end

  // Constant reset only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign sync_out = s.stable;

endmodule

// file: hdl/uag_ahb_slave.sv
// AHB-Lite slave front end for the byte registers of the port.
// Assumes single whole-word transfers; writes take no wait state, reads one.
`timescale 1ns/10ps

module uag_ahb_slave
  import uag_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Core side
  output uag_req_t         req,
  input  wire logic [7:0]  rdata
);

  typedef struct packed
  {
    uag_slv_state_t st;
    uag_sel_t       sel;
    logic [31:0]    rd;
  } uag_slv_t;

  uag_slv_t s;
  uag_slv_t next_s;
  logic     accept;
  uag_sel_t dec;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; upper address bits are not compared
  always_comb
  begin
    case (haddr[17:0])
      UAG_ADDR_DIR:   dec = UAG_SEL_DIR;
      UAG_ADDR_LATCH: dec = UAG_SEL_LATCH;
      UAG_ADDR_PULL:  dec = UAG_SEL_PULL;
      default:        dec = UAG_SEL_NONE;
    endcase
  end

  assign accept = hsel && htrans[1] && hready;

  // Read wait state lets a write just before a read land first
  always_comb
  begin
    next_s = s;
    case (s.st)
      UAG_SL_RDWAIT:
      begin
        next_s.rd = {UAG_PAD24, rdata};
        next_s.st = UAG_SL_RDDONE;
      end
      UAG_SL_IDLE, UAG_SL_WRITE, UAG_SL_RDDONE:
      begin
        if (accept)
        begin
          next_s.sel = dec;
          next_s.st  = hwrite ? UAG_SL_WRITE : UAG_SL_RDWAIT;
        end
        else
          next_s.st = UAG_SL_IDLE;
      end
      default:
        next_s.st = UAG_SL_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '{UAG_SL_IDLE, UAG_SEL_NONE, 32'h0000_0000};
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core strobes and bus answers
  assign req.wr    = (s.st == UAG_SL_WRITE);
  assign req.rd    = (s.st == UAG_SL_RDWAIT);
  assign req.sel   = s.sel;
  assign req.wdata = hwdata[7:0];
  assign hreadyout = (s.st != UAG_SL_RDWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = s.rd;

endmodule

// file: hdl/uag_port.sv
// Upper address / general purpose pin port, eight pins, top level.
// Assumes mode and hardware standby arrive as pins; software standby,
// the upper address byte and the DRAM controls come from on-chip logic
// on hclk. Pin levels are resolved outside from pin_out and pin_oe.
//
// Function
// - Modes 1-4: all pins drive upper address
// - Modes 5-6: direction one address, zero input
// - Modes 5-6: all pins input after reset
// - Mode 7: direction one output, zero input
// - Modes 1-4: direction fixed ones, writes ignored
// - Modes 5-7: direction write only, reads ones
// - Reset/hardware standby: direction FF or 00
// - Software standby: direction kept, outputs held
// - Output latch stored, driven on general outputs
// - Latch read: latch if output, else pin
// - Latch clears on reset and hardware standby, kept in software standby
// - Modes 5-7: pull-up needs input and enable
// - Pull-ups off modes 1-4, reset, hardware standby
// - Pull-up enable readable, cleared, kept
// - DRAM in area three: low pins row/column
// - Conditional pull-up: enable one, direction zero
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps

module uag_port
  import uag_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Chip operating state
  input  wire logic [2:0]  mode_pins,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  // Bus controller and DRAM refresh side
  input  wire logic [7:0]  upper_address_out,
  input  wire logic        dram_area3,
  input  wire logic        dram_cycle,
  input  wire logic [1:0]  dram_rowcol,
  // Package pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pullup_on
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the port
  typedef struct packed
  {
    logic [7:0] direction_bits;
    logic [7:0] latch_bits;
    logic [7:0] pullup_bits;
    logic [7:0] drive;
    logic [7:0] oe;
    logic [7:0] pull;
  } uag_port_t;

  uag_port_t  s;
  uag_port_t  next_s;

  uag_req_t   req;
  logic [7:0] rdata;
  logic [2:0] mode;
  logic       hws;
  logic [7:0] pin_sync;
  logic [7:0] addr_eff;

  // Next register values, kept apart from next_s so that the register
  // update and the pin update each own what they write
  logic [7:0] next_dir;
  logic [7:0] next_latch;
  logic [7:0] next_pull;

  // Mode group decodes
  logic       mode_known;
  logic       mode_exp;
  logic       mode_rom;
  logic       mode_gp;
  logic       mode_cond;

  // Per-pin drive decisions on the next register values
  logic [7:0] use_addr;
  logic [7:0] use_latch;
  logic [7:0] want_drive;
  logic [7:0] want_oe;
  logic [7:0] want_pull;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  uag_ahb_slave u_slave
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .req       (req),
    .rdata     (rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin-side inputs pass two flops before use
  uag_sync #(.WIDTH(12)) u_sync
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({mode_pins, hw_standby, pin_in}),
    .sync_out ({mode, hws, pin_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode groups; code zero is seen only while the strap sync fills,
  // and keeps the port quiet so modes 5-7 never see stray drive
  always_comb
  begin
    mode_known = (mode != UAG_MODE_NONE);
    mode_exp   = (mode >= UAG_MODE_1) && (mode <= UAG_MODE_4);
    mode_rom   = (mode == UAG_MODE_5) || (mode == UAG_MODE_6);
    mode_gp    = (mode == UAG_MODE_7);
    mode_cond  = mode_rom || mode_gp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address byte, with row/column bits on the two low pins for DRAM;
  // the swap is combinational, so it reaches the pins with the same
  // one-cycle lag as the rest of the address byte
  always_comb
  begin
    addr_eff = upper_address_out;
    if (dram_area3 && dram_cycle)
      addr_eff[UAG_DRAM_BITS-1:0] = dram_rowcol;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux; direction never shows its stored value.
  // Input bits come from the synced pins, so a level read here is two
  // cycles old: the price of keeping metastability off the bus
  always_comb
  begin
    case (req.sel)
      UAG_SEL_DIR:
        rdata = UAG_DIR_READ;
      UAG_SEL_LATCH:
        rdata = (s.direction_bits & s.latch_bits)
              | (~s.direction_bits & pin_sync);
      UAG_SEL_PULL:
        rdata = s.pullup_bits;
      default:
        rdata = UAG_ZERO8;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates
  always_comb
  begin
    next_dir   = s.direction_bits;
    next_latch = s.latch_bits;
    next_pull  = s.pullup_bits;

    // Bus writes act on the edge that ends the data phase
    if (req.wr)
    begin
      case (req.sel)
        UAG_SEL_DIR:
          if (mode_cond)
            next_dir = req.wdata;
        UAG_SEL_LATCH:
          next_latch = req.wdata;
        UAG_SEL_PULL:
          next_pull = req.wdata;
        default:
          next_latch = s.latch_bits;
      endcase
    end

    // Address-only modes pin the direction at ones; a write landing in
    // the same cycle loses, so the pins never see a stray input
    if (mode_exp)
      next_dir = UAG_DIR_RST_EXP;
    else if (!mode_known)
      next_dir = UAG_DIR_RST_GP;

    // Hardware standby acts like a held reset and beats any write
    if (hws)
    begin
      next_dir   = mode_exp ? UAG_DIR_RST_EXP
                            : UAG_DIR_RST_GP;
      next_latch = UAG_LATCH_RST;
      next_pull  = UAG_PULL_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin function select, taken from the next register values so a
  // written bit reaches its pin on the same edge as the register
  genvar gi;
  generate
    for (gi = 0; gi < UAG_W; gi++)
    begin : g_pin
      // Address drive: always in 1-4, by direction bit in 5-6
      assign use_addr[gi] = mode_exp
                         || (mode_rom && next_dir[gi]);
      // Latch drive only in single-chip mode with direction one
      assign use_latch[gi] = mode_gp
                          && next_dir[gi];
      assign want_drive[gi] = use_addr[gi] ? addr_eff[gi]
                                           : next_latch[gi];
      assign want_oe[gi] = use_addr[gi] || use_latch[gi];
      // Pull-up only on an input with its enable bit set
      assign want_pull[gi] = mode_cond
                          && !next_dir[gi]
                          && next_pull[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin register updates
  always_comb
  begin
    // Register part of the next state
    next_s.direction_bits = next_dir;
    next_s.latch_bits     = next_latch;
    next_s.pullup_bits    = next_pull;

    // Pin part, from the per-pin selects
    next_s.drive = want_drive;
    next_s.oe    = want_oe;
    next_s.pull  = want_pull;

    // Software standby freezes the pins at their present levels;
    // the pull-ups still follow their conditional setting
    if (sw_standby)
    begin
      next_s.drive = s.drive;
      next_s.oe    = s.oe;
    end

    // Hardware standby floats every pin and drops every pull-up
    if (hws || !mode_known)
    begin
      next_s.drive = UAG_ZERO8;
      next_s.oe    = UAG_ZERO8;
      next_s.pull  = UAG_ZERO8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; constant reset, direction settles by mode later.
  // The strap is not yet known under reset, so the direction starts at
  // zeros and modes 1-4 load ones once the synced mode shows
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s.direction_bits <= UAG_DIR_RST_GP;
      s.latch_bits     <= UAG_LATCH_RST;
      s.pullup_bits    <= UAG_PULL_RST;
      s.drive          <= UAG_ZERO8;
      s.oe             <= UAG_ZERO8;
      s.pull           <= UAG_ZERO8;
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs straight from flops
  assign pin_out   = s.drive;
  assign pin_oe    = s.oe;
  assign pullup_on = s.pull;

endmodule

// file: verification/uag_pin_model.sv
// Pin-side partner: resolves each package pin from every driver on it.
// Assumes the bench plays the outside world through ext_en and ext_val.
`timescale 1ns/10ps

module uag_pin_model
  import uag_pkg::*;
(
  // Clock
  input  wire logic       hclk,
  // Port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  // Outside world
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_lvl
);
  logic [7:0] last = 8'h00;
  logic [7:0] free;

  ////////////////////////////////////////////////////////////////////////////
  // Port drive wins, then outside drive, then pull-up; a floating pin
  // toggles so that no lucky constant hides a missing driver
  assign free    = ~pin_oe & ~ext_en;
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (free & pullup_on) | (free & ~pullup_on & ~last);

  // Last level, for the toggling of floating pins
  always @(posedge hclk)
    last <= pin_lvl;
endmodule

// file: verification/uag_port_monitor.sv
// Checker for the upper address pin port, bound to the top level.
// Assumes hready is the port's own hreadyout (single slave).
`timescale 1ns/10ps

module uag_port_monitor
  import uag_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Operating state and pins
  input wire logic [2:0]  mode_pins,
  input wire logic        hw_standby,
  input wire logic        sw_standby,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pullup_on
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic md14;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Address modes awake; mode and standby pass a two-stage sync first
  assign md14 = mode_pins inside {[3'h1:3'h4]} && !hw_standby;
  assign take = hsel && htrans[1] && hready;

  sequence rd_take;
    take && !hwrite;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
  a_read_wait: assert property (rd_take |=> rd_wait)
    else $error("read wait shape");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write waited");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("hrdata moved");
  a_addr_drive: assert property ((md14 && !sw_standby) [*4] |=>
    pin_oe == 8'hff) else $error("address pins off");
  a_pull_addr: assert property (md14 [*4] |=> pullup_on == 8'h00)
    else $error("pull-up in address mode");
  a_hw_off: assert property (hw_standby [*3] |=>
    pin_oe == 8'h00 && pullup_on == 8'h00) else $error("standby drive");
  a_pull_input: assert property (!sw_standby && !$past(sw_standby) |->
    (pullup_on & pin_oe) == 8'h00) else $error("pull-up on output");
  a_sw_hold: assert property ((sw_standby && !hw_standby) [*4] |=>
    $stable(pin_oe)) else $error("drive moved in standby");
endmodule

bind uag_port uag_port_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .mode_pins(mode_pins), .hw_standby(hw_standby), .sw_standby(sw_standby),
  .pin_oe(pin_oe), .pullup_on(pullup_on));

// file: verification/test_uag_port.sv
// Self-checking bench for the upper address pin port.
// Assumes one AHB-Lite slave, so hready is the port's hreadyout.
`timescale 1ns/10ps

module test_uag_port;
  import uag_pkg::*;

  localparam logic [31:0] A_DIR  = {14'h0, UAG_ADDR_DIR};
  localparam logic [31:0] A_LAT  = {14'h0, UAG_ADDR_LATCH};
  localparam logic [31:0] A_PULL = {14'h0, UAG_ADDR_PULL};
  localparam logic [31:0] A_NONE = 32'h0000_0100;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0]  mode_pins = 3'h7;
  logic        hw_standby = 1'b0;
  logic        sw_standby = 1'b0;
  logic        dram_area3 = 1'b0;
  logic        dram_cycle = 1'b0;
  logic [1:0]  dram_rowcol = 2'h0;
  logic [7:0]  ext_en = 8'h0f;
  logic [7:0]  ext_val = 8'h0c;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  pullup_on;
  int          num_errors = 0;
  int          cmp_count = 0;

  // 40 MHz clock
  always #12.5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // Design and pin world
  uag_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mode_pins(mode_pins),
    .hw_standby(hw_standby), .sw_standby(sw_standby),
    .upper_address_out(8'h96), .dram_area3(dram_area3),
    .dram_cycle(dram_cycle), .dram_rowcol(dram_rowcol), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on));
  uag_pin_model u_pins (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, the only exit of the run
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Wait for hready sampled high; sampled half a cycle early to stay
  // clear of the edge race, since it stands until that edge
  task automatic wt();
    int   n;
    logic ok;
    n = 0;
    do
    begin
      @(negedge hclk);
      ok = (hready_w() === 1'b1);
      rd = hrdata;
      @(posedge hclk);
      n++;
    end while (!ok && n < 64);
    if (!ok)
    begin
      num_errors++;
      close_out();
    end
  endtask

  function automatic logic hready_w();
    return hreadyout;
  endfunction

  // One single word transfer, byte in the low lane
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [7:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hwdata <= {UAG_PAD24, d};
    wt();
  endtask

  task automatic rdc(input string nm, input logic [31:0] a,
                     input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, {UAG_PAD24, e});
  endtask

  task automatic pins(input logic [7:0] oe, pu, om, ov);
    @(negedge hclk);
    chk("pin_oe", pin_oe, oe);
    chk("pullup_on", pullup_on, pu);
    chk("pin_out", pin_out & om, ov);
    @(posedge hclk);
  endtask

  // Mode is a strap: it changes only under reset
  task automatic rst(input logic [2:0] m);
    hresetn <= 1'b0;
    mode_pins <= m;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int m = 1; m < 8; m++)
    begin
      rst(3'(m));
      pins(m < 5 ? 8'hff : 8'h00, 8'h00, 8'h00, 8'h00);
    end
    $display("Mode loop done");
    rdc("dir", A_DIR, 8'hff);
    rdc("pull", A_PULL, 8'h00);
    bus(1'b1, A_PULL, 8'hff);
    repeat (3) @(posedge hclk);
    rdc("latch", A_LAT, 8'hfc);
    bus(1'b1, A_DIR, 8'hf0);
    bus(1'b1, A_LAT, 8'ha5);
    pins(8'hf0, 8'h0f, 8'hf0, 8'ha0);
    rdc("latch", A_LAT, 8'hac);
    rdc("dir", A_DIR, 8'hff);
    bus(1'b1, A_NONE, 8'h55);
    rdc("unmapped", A_NONE, 8'h00);
    sw_standby <= 1'b1;
    repeat (8) @(posedge hclk);
    pins(8'hf0, 8'h0f, 8'hf0, 8'ha0);
    bus(1'b1, A_LAT, 8'h5a);
    pins(8'hf0, 8'h0f, 8'hf0, 8'ha0);
    sw_standby <= 1'b0;
    @(posedge hclk);
    pins(8'hf0, 8'h0f, 8'hf0, 8'h50);
    rdc("pull", A_PULL, 8'hff);
    hw_standby <= 1'b1;
    repeat (4) @(posedge hclk);
    pins(8'h00, 8'h00, 8'hff, 8'h00);
    hw_standby <= 1'b0;
    repeat (4) @(posedge hclk);
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    rdc("pull", A_PULL, 8'h00);
    bus(1'b1, A_DIR, 8'hff);
    rdc("latch", A_LAT, 8'h00);
    $display("Mode 7 test done");
    rst(3'h5);
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    bus(1'b1, A_DIR, 8'h0f);
    bus(1'b1, A_PULL, 8'hff);
    pins(8'h0f, 8'hf0, 8'h0f, 8'h06);
    $display("Mode 5 test done");
    rst(3'h2);
    bus(1'b1, A_DIR, 8'h00);
    bus(1'b1, A_PULL, 8'hff);
    pins(8'hff, 8'h00, 8'hff, 8'h96);
    rdc("dir", A_DIR, 8'hff);
    dram_area3 <= 1'b1;
    dram_cycle <= 1'b1;
    dram_rowcol <= 2'h1;
    repeat (2) @(posedge hclk);
    pins(8'hff, 8'h00, 8'hff, 8'h95);
    $display("Mode 2 test done");
    close_out();
  end
endmodule
